/* File: hdl/external_memory_bus_interface.sv */
// External parallel bus interface: strobes, wait states, reset and visibility
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_consts.svh"
module external_memory_bus_interface (
	input  wire logic                  sys_clk,
	input  wire logic                  nrst,
	input  wire logic                  accReq,
	input  wire logic                  accWrite,
	input  wire ext_bus_pkg::space_t   accSpace,
	input  wire logic [15:0]           accWdata,
	input  wire logic [`EB_WAIT_W-1:0] waitStates,
	input  wire logic                  powerDown,
	input  wire logic                  watchdogOverflow,
	input  wire logic                  visibilityModeClear,
	input  wire logic                  readyPin,
	input  wire logic                  externalInterfaceEnablePin,
	input  wire logic                  emulationFloatControlPin,
	input  wire logic                  bootMemorySelectPin,
	input  wire logic                  deviceResetPinIn,
	input  wire logic [15:0]           dataBusIn,
	output logic                       accDone,
	output logic [15:0]                accRdata,
	output logic                       illegalAddress,
	output logic                       programSpaceSelectN,
	output logic                       programSpaceSelectOe,
	output logic                       dataSpaceSelectN,
	output logic                       dataSpaceSelectOe,
	output logic                       ioSpaceSelectN,
	output logic                       ioSpaceSelectOe,
	output logic                       globalDataStrobeN,
	output logic                       globalDataStrobeOe,
	output logic                       writeStrobeN,
	output logic                       writeStrobeOe,
	output logic                       readStrobeN,
	output logic                       readStrobeOe,
	output logic                       readWriteDir,
	output logic                       readWriteDirOe,
	output logic                       externalAccessStrobeN,
	output logic                       externalAccessStrobeOe,
	output logic [15:0]                dataBusOut,
	output logic                       dataBusOe,
	output logic                       visibilityClock,
	output logic                       visibilityOutputEnableN,
	output logic                       clockOutput,
	output logic                       addressVisibilityMode,
	output logic                       bootExternal,
	output logic [15:0]                programCounter,
	output logic                       cpuHalted,
	output logic                       deviceResetPinOut,
	output logic                       deviceResetPinOe
);
	import ext_bus_pkg::*;

	bus_state_t              state;
	space_t                  curSpace;
	logic                    curWrite;
	logic [`EB_WAIT_W-1:0]   waitCnt;
	logic                    enaSync;
	logic                    emuSync;
	logic                    rdySync;
	logic                    bootSync;
	logic                    rstPinSync;
	logic                    rstPinPrev;
	logic [3:0]              wdogCnt;
	logic                    floatAll;
	logic                    inReset;
	logic                    busy;
	logic                    next_readyOk;

	pin_sync u_ena (
		.sys_clk   (sys_clk),
		.nrst      (nrst),
		.resetValue(1'b0),
		.pinIn     (externalInterfaceEnablePin),
		.pinOut    (enaSync)
	);
	pin_sync u_emu (
		.sys_clk   (sys_clk),
		.nrst      (nrst),
		.resetValue(1'b0),
		.pinIn     (emulationFloatControlPin),
		.pinOut    (emuSync)
	);
	pin_sync u_rdy (
		.sys_clk   (sys_clk),
		.nrst      (nrst),
		.resetValue(1'b0),
		.pinIn     (readyPin),
		.pinOut    (rdySync)
	);
	pin_sync u_boot (
		.sys_clk   (sys_clk),
		.nrst      (nrst),
		.resetValue(1'b0),
		.pinIn     (bootMemorySelectPin),
		.pinOut    (bootSync)
	);
	pin_sync u_rst (
		.sys_clk   (sys_clk),
		.nrst      (nrst),
		.resetValue(1'b0),
		.pinIn     (deviceResetPinIn),
		.pinOut    (rstPinSync)
	);

	// Reset pin low, or the pulse we drive, holds the core in reset
	assign inReset  = !rstPinSync || (wdogCnt != 4'h0);
	// Emulation float is active low; synchroniser reads low until it settles
	assign floatAll = !emuSync;
	assign busy     = (state != ST_IDLE);
	// READY resampled every wait cycle; ignored with no software wait states
	assign next_readyOk = (waitStates == '0) ? 1'b1 : rdySync;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wdogCnt <= 4'h0;
		end else if (watchdogOverflow && wdogCnt == 4'h0) begin
			wdogCnt <= `EB_WDOG_PULSE_CYC;
		end else if (wdogCnt != 4'h0) begin
			wdogCnt <= wdogCnt - 4'h1;
		end
	end
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			deviceResetPinOut <= 1'b0;
			deviceResetPinOe  <= 1'b0;
		end else begin
			deviceResetPinOut <= 1'b0;
			deviceResetPinOe  <= (watchdogOverflow && wdogCnt == 4'h0) || (wdogCnt > 4'h1);
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			programCounter <= `EB_PC_RESET;
			cpuHalted      <= 1'b1;
			rstPinPrev     <= 1'b0;
		end else begin
			rstPinPrev <= inReset;
			cpuHalted  <= inReset;
			if (inReset) begin
				programCounter <= `EB_PC_RESET;
			end else if (rstPinPrev) begin
				programCounter <= `EB_BOOT_ADDR;
			end
		end
	end

	// Boot select caught in reset and one cycle on, as its pin lags like the reset pin
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			bootExternal <= 1'b0;
		end else if (inReset || rstPinPrev) begin
			bootExternal <= bootSync;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			addressVisibilityMode <= 1'b1;
		end else if (inReset) begin
			addressVisibilityMode <= 1'b1;
		end else if (visibilityModeClear) begin
			addressVisibilityMode <= 1'b0;
		end
	end

	// Bus cycle sequencer with wait states
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state    <= ST_IDLE;
			curSpace <= SPACE_PROG;
			curWrite <= 1'b0;
			waitCnt  <= '0;
		end else if (inReset) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (accReq && enaSync) begin
						curSpace <= accSpace;
						curWrite <= accWrite;
						waitCnt  <= waitStates;
						// Registered strobes fall a cycle after the take, so data is never sampled earlier
						state    <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (waitCnt <= `EB_WAIT_W'(1)) begin
						state <= ST_RDY;
					end else begin
						waitCnt <= waitCnt - `EB_WAIT_W'(1);
					end
				end
				ST_RDY: begin
					// READY only counts with wait states
					if (next_readyOk) begin
						state <= ST_DONE;
					end
				end
				ST_DONE: state <= ST_IDLE;
				default: state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			illegalAddress <= 1'b0;
			accDone        <= 1'b0;
			accRdata       <= 16'h0000;
		end else begin
			illegalAddress <= accReq && !enaSync && state == ST_IDLE && !inReset;
			accDone        <= (state == ST_RDY) && next_readyOk && !inReset;
			if (state == ST_RDY && next_readyOk && !curWrite) begin
				accRdata <= dataBusIn;
			end
		end
	end

	// One space select from the decoded space
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			programSpaceSelectN <= 1'b1;
			dataSpaceSelectN    <= 1'b1;
			ioSpaceSelectN      <= 1'b1;
			globalDataStrobeN   <= 1'b1;
		end else begin
			programSpaceSelectN <= !(busy && curSpace == SPACE_PROG);
			dataSpaceSelectN    <= !(busy && (curSpace == SPACE_DATA || curSpace == SPACE_GLOB));
			ioSpaceSelectN      <= !(busy && curSpace == SPACE_IO);
			globalDataStrobeN   <= !(busy && curSpace == SPACE_GLOB);
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			writeStrobeN          <= 1'b1;
			readStrobeN           <= 1'b1;
			readWriteDir          <= 1'b1;
			externalAccessStrobeN <= 1'b1;
		end else begin
			writeStrobeN          <= !(busy && curWrite);
			readStrobeN           <= !(busy && !curWrite);
			readWriteDir          <= !(busy && curWrite);
			externalAccessStrobeN <= !busy;
		end
	end

	// Float selects in reset, power down, emulation float
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			programSpaceSelectOe   <= 1'b0;
			dataSpaceSelectOe      <= 1'b0;
			ioSpaceSelectOe        <= 1'b0;
			globalDataStrobeOe     <= 1'b0;
			writeStrobeOe          <= 1'b0;
			readStrobeOe           <= 1'b0;
			readWriteDirOe         <= 1'b0;
			externalAccessStrobeOe <= 1'b0;
		end else begin
			programSpaceSelectOe   <= enaSync && !inReset && !powerDown && !floatAll;
			dataSpaceSelectOe      <= enaSync && !inReset && !powerDown && !floatAll;
			ioSpaceSelectOe        <= enaSync && !inReset && !powerDown && !floatAll;
			globalDataStrobeOe     <= enaSync && !inReset && !powerDown && !floatAll;
			// Write and read strobes float only under emulation float or with the interface disabled
			writeStrobeOe          <= enaSync && !floatAll;
			readStrobeOe           <= enaSync && !floatAll;
			readWriteDirOe         <= enaSync && !powerDown && !floatAll;
			externalAccessStrobeOe <= enaSync && !powerDown && !floatAll;
		end
	end

	// Data bus drive from write strobe fall or visibility mode
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			dataBusOut <= 16'h0000;
			dataBusOe  <= 1'b0;
		end else begin
			if (busy && curWrite) begin
				dataBusOut <= accWdata;
			end
			dataBusOe <= enaSync && !floatAll && ((busy && curWrite) || addressVisibilityMode);
		end
	end

	// Visibility output enable follows data drive in visibility mode only; high otherwise
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			visibilityOutputEnableN <= 1'b1;
		end else begin
			visibilityOutputEnableN <= !(addressVisibilityMode && enaSync && !floatAll
				&& ((busy && curWrite) || addressVisibilityMode));
		end
	end

	// Visibility clock mirrors clock output; both run at half the system clock rate
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			clockOutput     <= 1'b0;
			visibilityClock <= 1'b0;
		end else begin
			clockOutput     <= !clockOutput;
			visibilityClock <= !clockOutput;
		end
	end

	AST_ONE_SELECT: assert property (@(posedge sys_clk) disable iff (!nrst)
		(!programSpaceSelectN + !dataSpaceSelectN + !ioSpaceSelectN) <= 1)
		else $error("More than one space select asserted");
	AST_WDOG_PULSE: assert property (@(posedge sys_clk) disable iff (!nrst)
		$rose(deviceResetPinOe) |-> deviceResetPinOe [*8] ##1 !deviceResetPinOe)
		else $error("Watchdog reset pulse not eight cycles");
	AST_VISIBILITY_CLOCK: assert property (@(posedge sys_clk) disable iff (!nrst)
		visibilityClock == clockOutput)
		else $error("Visibility clock differs from clock output");
	AST_DATA_ON_WRITE: assert property (@(posedge sys_clk) disable iff (!nrst)
		$fell(writeStrobeN) && writeStrobeOe |-> dataBusOe)
		else $error("Data bus not driven at write strobe fall");
	AST_ONE_STROBE: assert property (@(posedge sys_clk) disable iff (!nrst)
		externalAccessStrobeN ? (readStrobeN && writeStrobeN) : (readStrobeN != writeStrobeN))
		else $error("Read and write strobes disagree with access strobe");
	AST_FLOAT_IN_RESET: assert property (@(posedge sys_clk) disable iff (!nrst)
		cpuHalted |-> !(programSpaceSelectOe || dataSpaceSelectOe || ioSpaceSelectOe || globalDataStrobeOe))
		else $error("Space select driven while in reset");
endmodule
`default_nettype wire

/* File: inc/ext_bus_consts.svh */
// Constants of the external memory bus interface
// Behaviour
// - Space selects idle high; one goes low only during its external space access.
// - Space selects float during reset, power down and emulation float.
// - Data bus is driven from the falling edge of the write strobe.
// - Write strobe active on every external write; floats under emulation float.
// - Read strobe active on every external read; floats under emulation float.
// - Direction line high, low only for writes; floats in power down or float.
// - Access strobe low for each off-chip cycle; floats in power down or float.
// - Global data strobe asserted for accesses to external global data space.
// - Global data strobe floats during reset, power down and emulation float.
// - A low READY inserts wait states; READY is resampled each cycle until high.
// - READY is sampled only when at least one software wait state is set.
// - External signals are enabled only while the interface enable pin is high.
// - With interface disabled, external accesses raise an illegal-address condition.
// - Visibility clock follows the clock output, aligned to the bus.
// - In visibility mode, visibility output enable low while data bus is driven.
// - Boot select sampled at reset: low internal flash, high external program memory.
// - Reset pin low stops execution and clears the program counter to zero.
// - Watchdog overflow drives an eight-cycle reset pulse onto the reset pin.
// - Address visibility mode is on after reset; data bus stays output meanwhile.
`ifndef EXT_BUS_CONSTS_SVH
`define EXT_BUS_CONSTS_SVH
`define EB_WDOG_PULSE_CYC 4'h8
`define EB_WAIT_W 3
`define EB_PC_RESET 16'h0000
`define EB_BOOT_ADDR 16'h0000
`endif

/* File: inc/ext_bus_pkg.sv */
// Types of the external memory bus interface
package ext_bus_pkg;
	typedef enum logic [1:0] {
		SPACE_PROG = 2'h0,
		SPACE_DATA = 2'h1,
		SPACE_IO   = 2'h2,
		SPACE_GLOB = 2'h3
	} space_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_WAIT = 2'h1,
		ST_RDY  = 2'h2,
		ST_DONE = 2'h3
	} bus_state_t;
endpackage

/* File: hdl/pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
	input  wire logic sys_clk,
	input  wire logic nrst,
	input  wire logic resetValue,
	input  wire logic pinIn,
	output var  logic pinOut
);
	logic stage1;
	logic stage2;
	logic stage3;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
		end else begin
			stage1 <= pinIn;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// Output moves only once stages two and three agree
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pinOut <= 1'b0;
		end else if (stage2 == stage3) begin
			pinOut <= stage3;
		end
	end
	wire logic unusedReset = resetValue;
endmodule
`default_nettype wire

/* File: testbench/ext_mem_model.sv */
// Behavioural external memory device on the parallel bus
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
	input  wire logic        sys_clk,
	input  wire logic        externalAccessStrobeN,
	input  wire logic        readStrobeN,
	input  wire logic        writeStrobeN,
	input  wire logic        dataBusOe,
	input  wire logic [15:0] dataBusOut,
	input  wire logic [3:0]  stallCycles,
	output logic             readyPin,
	output var logic [15:0]  dataBusIn,
	output var logic [15:0]  stored
);
	logic [3:0] count;
	initial begin
		count = 4'h0;
		stored = 16'h5A3C;
	end
	always @(posedge sys_clk) begin
		if (!externalAccessStrobeN && count != 4'hF) count <= count + 4'h1;
		else if (externalAccessStrobeN) count <= 4'h0;
		if (!writeStrobeN && dataBusOe) stored <= dataBusOut;
	end
	assign readyPin = externalAccessStrobeN || (count >= stallCycles);
	// Data pins have pull-downs, so a released bus reads zero
	assign dataBusIn = dataBusOe ? dataBusOut : (!readStrobeN ? stored : 16'h0000);
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench of the external memory bus interface
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ext_bus_pkg::*;
	logic sys_clk, nrst, accReq, accWrite, powerDown, watchdogOverflow, visibilityModeClear;
	logic externalInterfaceEnablePin, emulationFloatControlPin, bootMemorySelectPin;
	space_t accSpace;
	logic [15:0] accWdata, accRdata, dataBusIn, dataBusOut, programCounter, stored;
	logic [2:0] waitStates;
	logic [3:0] stallCycles;
	logic readyPin, deviceResetPinIn, accDone, illegalAddress, programSpaceSelectN, programSpaceSelectOe;
	logic dataSpaceSelectN, dataSpaceSelectOe, ioSpaceSelectN, ioSpaceSelectOe, globalDataStrobeN;
	logic globalDataStrobeOe, writeStrobeN, writeStrobeOe, readStrobeN, readStrobeOe, readWriteDir;
	logic readWriteDirOe, externalAccessStrobeN, externalAccessStrobeOe, dataBusOe, visibilityClock;
	logic visibilityOutputEnableN, clockOutput, addressVisibilityMode, bootExternal, cpuHalted;
	logic deviceResetPinOut, deviceResetPinOe;
	int mismatches, num_checks, cycles;
	wire logic [7:0] allOe = {programSpaceSelectOe, dataSpaceSelectOe, ioSpaceSelectOe, globalDataStrobeOe,
		writeStrobeOe, readStrobeOe, readWriteDirOe, externalAccessStrobeOe};
	wire logic [7:0] allN = {programSpaceSelectN, dataSpaceSelectN, ioSpaceSelectN, globalDataStrobeN,
		writeStrobeN, readStrobeN, readWriteDir, externalAccessStrobeN};
	// Reset pin is pulled high on the board
	assign deviceResetPinIn = deviceResetPinOe ? deviceResetPinOut : 1'b1;
	external_memory_bus_interface DUT (.sys_clk, .nrst, .accReq, .accWrite, .accSpace, .accWdata,
		.waitStates, .powerDown, .watchdogOverflow, .visibilityModeClear, .readyPin,
		.externalInterfaceEnablePin, .emulationFloatControlPin, .bootMemorySelectPin, .deviceResetPinIn,
		.dataBusIn, .accDone, .accRdata, .illegalAddress, .programSpaceSelectN, .programSpaceSelectOe,
		.dataSpaceSelectN, .dataSpaceSelectOe, .ioSpaceSelectN, .ioSpaceSelectOe, .globalDataStrobeN,
		.globalDataStrobeOe, .writeStrobeN, .writeStrobeOe, .readStrobeN, .readStrobeOe, .readWriteDir,
		.readWriteDirOe, .externalAccessStrobeN, .externalAccessStrobeOe, .dataBusOut, .dataBusOe,
		.visibilityClock, .visibilityOutputEnableN, .clockOutput, .addressVisibilityMode, .bootExternal,
		.programCounter, .cpuHalted, .deviceResetPinOut, .deviceResetPinOe);
	ext_mem_model model (.sys_clk, .externalAccessStrobeN, .readStrobeN, .writeStrobeN, .dataBusOe,
		.dataBusOut, .stallCycles, .readyPin, .dataBusIn, .stored);
	always #12.5 sys_clk = ~sys_clk;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// One external cycle; selN lists {global, io, data, program} selects expected low
	task automatic access(input space_t sp, input logic wr, input logic [2:0] ws, input logic [3:0] st,
		input logic [3:0] selN);
		logic [3:0] saw;
		logic [4:0] act;
		logic bad;
		logic [15:0] wd;
		int n;
		saw = 4'h0;
		act = 5'h0;
		bad = 1'b0;
		n = 0;
		wd = {4'hA, ws, 1'b0, st, 4'h5};
		@(posedge sys_clk);
		waitStates <= ws;
		stallCycles <= st;
		@(posedge sys_clk);
		accSpace <= sp;
		accWrite <= wr;
		accWdata <= wd;
		accReq <= 1'b1;
		do begin
			@(negedge sys_clk);
			n++;
			saw |= {~globalDataStrobeN, ~ioSpaceSelectN, ~dataSpaceSelectN, ~programSpaceSelectN};
			act |= {dataBusOe, ~readWriteDir, ~writeStrobeN, ~readStrobeN, ~externalAccessStrobeN};
			bad |= (visibilityClock !== clockOutput)
				|| (addressVisibilityMode && dataBusOe && visibilityOutputEnableN !== 1'b0);
		end while (accDone !== 1'b1 && n < 60);
		@(posedge sys_clk) accReq <= 1'b0;
		check(saw, selN);
		check(act, {wr, wr, wr, ~wr, 1'b1});
		check(bad, 1'b0);
		check(ws == 3'h0 ? (n < 5) : (n > st), 1'b1);
		check(wr ? stored : accRdata, wr ? wd : stored);
		$display("access space %0d write %0d done in %0d", sp, wr, n);
	endtask
	task automatic float_test();
		@(posedge sys_clk) powerDown <= 1'b1;
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk);
		check(allOe & 8'hF3, 8'h00);
		@(posedge sys_clk) powerDown <= 1'b0;
		emulationFloatControlPin <= 1'b0;
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk);
		check(allOe, 8'h00);
		@(posedge sys_clk) emulationFloatControlPin <= 1'b1;
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk);
		check(allN, 8'hFF);
		$display("float test done");
	endtask
	task automatic disabled_test();
		int hits;
		logic strobed;
		hits = 0;
		strobed = 1'b0;
		@(posedge sys_clk) externalInterfaceEnablePin <= 1'b0;
		repeat (8) @(posedge sys_clk);
		accSpace <= SPACE_IO;
		accWrite <= 1'b0;
		accReq <= 1'b1;
		repeat (4) begin
			@(negedge sys_clk);
			hits += (illegalAddress === 1'b1);
			strobed |= ~externalAccessStrobeN | ~ioSpaceSelectN | ~readStrobeN;
		end
		@(posedge sys_clk) accReq <= 1'b0;
		externalInterfaceEnablePin <= 1'b1;
		check(hits > 0, 1'b1);
		check(strobed, 1'b0);
		repeat (8) @(posedge sys_clk);
		$display("disabled test done");
	endtask
	task automatic watchdog_test();
		int width;
		logic halted;
		logic [15:0] pcHalt;
		width = 0;
		halted = 1'b0;
		pcHalt = 16'hFFFF;
		@(posedge sys_clk) bootMemorySelectPin <= 1'b0;
		watchdogOverflow <= 1'b1;
		@(posedge sys_clk) watchdogOverflow <= 1'b0;
		repeat (30) begin
			@(negedge sys_clk);
			width += (deviceResetPinOe === 1'b1 && deviceResetPinOut === 1'b0);
			halted |= cpuHalted;
			if (cpuHalted === 1'b1) pcHalt = programCounter;
		end
		check(width, 16'h0008);
		check(halted, 1'b1);
		check(pcHalt, 16'h0000);
		check(bootExternal, 1'b0);
		check(addressVisibilityMode, 1'b1);
		@(posedge sys_clk) visibilityModeClear <= 1'b1;
		@(posedge sys_clk) visibilityModeClear <= 1'b0;
		repeat (2) @(posedge sys_clk);
		check(addressVisibilityMode, 1'b0);
		$display("watchdog test done");
	endtask
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			mismatches++;
			report_and_stop();
		end
	end
	initial begin
		{sys_clk, nrst, accReq, accWrite, powerDown, watchdogOverflow, visibilityModeClear} = 7'h00;
		{externalInterfaceEnablePin, emulationFloatControlPin, bootMemorySelectPin} = 3'h7;
		accSpace = SPACE_PROG;
		accWdata = 16'h0000;
		waitStates = 3'h0;
		stallCycles = 4'h0;
		mismatches = 0;
		num_checks = 0;
		cycles = 0;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		check(allOe[7:4], 4'h0);
		check(programCounter, 16'h0000);
		@(posedge sys_clk) nrst <= 1'b1;
		repeat (10) @(posedge sys_clk);
		check(bootExternal, 1'b1);
		check(addressVisibilityMode, 1'b1);
		access(SPACE_IO, 1'b1, 3'h7, 4'hC, 4'b0100);
		// Reads need the bus released, so visibility mode goes off first
		@(posedge sys_clk) visibilityModeClear <= 1'b1;
		@(posedge sys_clk) visibilityModeClear <= 1'b0;
		access(SPACE_DATA, 1'b0, 3'h0, 4'hC, 4'b0010);
		access(SPACE_PROG, 1'b0, 3'h5, 4'hC, 4'b0001);
		access(SPACE_GLOB, 1'b1, 3'h0, 4'h0, 4'b1010);
		float_test();
		disabled_test();
		watchdog_test();
		report_and_stop();
	end
endmodule
`default_nettype wire
